/* File: hdl/gp_port_map.svh */
// Constants for the I/O port: register selects, alias codes, field positions
// and reset values. Assumes inclusion by bare name from the port package.
`ifndef GP_PORT_MAP_SVH
`define GP_PORT_MAP_SVH

`define GP_W          16
`define GP_SEL_W      4
// Register selects
`define GP_R_DIR      4'h0
`define GP_R_LAT      4'h1
`define GP_R_ODC      4'h2
`define GP_R_ANS      4'h3
`define GP_R_CNEN     4'h4
`define GP_R_CNNE     4'h5
`define GP_R_CNCON    4'h6
`define GP_R_CNPU     4'h7
`define GP_R_CNPD     4'h8
`define GP_R_SRH      4'h9
`define GP_R_SRL      4'hA
`define GP_R_PORT     4'hB
`define GP_R_CNSTAT   4'hC
`define GP_R_CNF      4'hD
`define GP_NSTORE     11
// Write/read alias codes
`define GP_OP_BASE    2'h0
`define GP_OP_CLR     2'h1
`define GP_OP_SET     2'h2
`define GP_OP_INV     2'h3
// Field positions and reset values
`define GP_EDGE_BIT   11
`define GP_CNCON_MASK 16'h0800
`define GP_ONES       16'hFFFF
`define GP_ZERO       16'h0000

`endif

/* File: hdl/gp_port_pkg.sv */
// Types shared by the I/O port modules.
// Assumes the constant header is on the include path.
`include "gp_port_map.svh"

package gp_port_pkg;
    typedef enum logic [1:0] {
        GP_BASE = `GP_OP_BASE,
        GP_CLR  = `GP_OP_CLR,
        GP_SET  = `GP_OP_SET,
        GP_INV  = `GP_OP_INV
    } gp_op_t;

    typedef struct packed {
        logic                 en;
        logic [`GP_SEL_W-1:0] sel;
        gp_op_t               op;
        logic [`GP_W-1:0]     data;
    } gp_wr_t;

    typedef struct packed {
        logic                 en;
        logic [`GP_SEL_W-1:0] sel;
        gp_op_t               op;
    } gp_rd_t;
endpackage

/* File: hdl/gp_sync.sv */
// Three-stage pin input synchroniser with agreement filter.
// Assumes asynchronous pin levels and a single bus clock.
`timescale 1ns/100ps

module gp_sync #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // A bit moves only once stages two and three agree
    always_comb begin
        next_q = (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3)); // [RQ22]
    end

    // Capture chain; the first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule

/* File: hdl/gp_change.sv */
// Change-notice detector: mismatch status, sticky edge flags, request.
// Assumes a synchronised level and a one-cycle pin-level read strobe.
`timescale 1ns/100ps

module gp_change #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] level,
    input  wire logic         mode,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    input  wire logic         port_rd,
    input  wire logic         flag_wr,
    input  wire logic [W-1:0] flag_wr_val,
    output logic      [W-1:0] stat,
    output logic      [W-1:0] flag,
    output logic              irq
);
    logic [W-1:0] ref_lvl;
    logic [W-1:0] prev;
    logic [W-1:0] hit;
    logic [W-1:0] next_ref;
    logic [W-1:0] next_stat;
    logic [W-1:0] next_flag;
    logic         next_irq;

    // Reference follows each pin-level read; edges set flags, set wins
    always_comb begin
        next_ref  = port_rd ? level : ref_lvl;
        next_stat = level ^ next_ref;                                    // [RQ14]
        hit       = mode ? ((level & ~prev & rise_en) | (~level & prev & fall_en))
                         : '0;                                           // [RQ13]
        next_flag = (flag_wr ? flag_wr_val : flag) | hit;                // [RQ15]
        next_irq  = mode ? (|next_flag) : (|(next_stat & rise_en));      // [RQ11] [RQ12]
    end

    // Detector state; runs on the port clock independent of the core
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ref_lvl <= '0;
            prev    <= '0;
            stat    <= '0;
            flag    <= '0;
            irq     <= 1'b0;
        end else begin
            ref_lvl <= next_ref;
            prev    <= level;
            stat    <= next_stat;
            flag    <= next_flag;
            irq     <= next_irq;                                         // [RQ10]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_flag_set_wins: assert property ( // [RQ15]
        mode && flag_wr && ((level & ~prev & rise_en) != 0)
        |=> (flag & $past(level & ~prev & rise_en)) == $past(level & ~prev & rise_en))
        else $error("edge flag lost against a clear");

    a_mismatch_irq: assert property ( // [RQ12]
        !mode && ((next_stat & rise_en) != 0) |=> irq)
        else $error("mismatch did not raise request");
endmodule

/* File: hdl/gp_port.sv */
// I/O port with direction, latch, open-drain, analog select, change notice,
// weak pulls, slew codes and clear/set/invert write aliases.
// Assumes one bus clock MCLK, pins outside the domain, a register port below.
//
// Summary of operation
// RQ1: Direction bit one makes pin input; zero drives it from the latch.
// RQ2: Every reset leaves all direction bits set, so all pins are inputs.
// RQ3: Latch register reads return the latch; writes update the latch.
// RQ4: Pin-level reads return sampled pins; writes go to the latch.
// RQ5: Open-drain pins drive only low and release instead of driving high.
// RQ6: Software sets analog and direction for analog use; clears analog for digital.
// RQ7: Analog select resets to all ones, so shared pins start analog.
// RQ8: Pin-level reads return zero for pins set as analog inputs.
// RQ9: Software waits one instruction between a direction or port write and read.
// RQ10: Change detection runs independent of core clocking and raises a request.
// RQ11: Each pin has a change-notice enable that lets it request.
// RQ12: With edge mode bit 11 clear, rise enables arm mismatch requests.
// RQ13: In edge mode, fall enables arm falling edges, rise enables rising.
// RQ14: In mismatch mode, status shows change since the last pin-level read.
// RQ15: In edge mode, the sticky edge flag records an armed edge.
// RQ16: Separate per-pin weak pull-up and pull-down enables drive pull controls.
// RQ17: Software keeps pulls disabled on pins used as digital outputs.
// RQ18: Slew code high,low: 11 slowest, 10 slow, 01 medium, 00 fastest.
// RQ19: After reset every slew code is 00, fastest with control off.
// RQ20: Set, clear, invert aliases change only bits written as one.
// RQ21: Alias reads return no meaningful data; here they return zero.
// RQ22: Pin inputs are synchronised before readback and change detection.
`timescale 1ns/100ps
`include "gp_port_map.svh"

module gp_port (
    input  wire logic                  MCLK,
    input  wire logic                  RSTN,
    input  wire gp_port_pkg::gp_wr_t   REG_WR,
    input  wire gp_port_pkg::gp_rd_t   REG_RD,
    output logic [`GP_W-1:0]           RD_DATA,
    input  wire logic [`GP_W-1:0]      PIN_IN,
    output logic [`GP_W-1:0]           PIN_OUT,
    output logic [`GP_W-1:0]           PIN_OE,
    output logic [`GP_W-1:0]           ANALOG_EN,
    output logic [`GP_W-1:0]           PULL_UP,
    output logic [`GP_W-1:0]           PULL_DN,
    output logic [`GP_W-1:0]           SLEW_HI,
    output logic [`GP_W-1:0]           SLEW_LO,
    output logic                       CN_IRQ
);
    import gp_port_pkg::*;

    logic [`GP_W-1:0] r [`GP_NSTORE];
    logic [`GP_W-1:0] next_r [`GP_NSTORE];
    logic [`GP_W-1:0] level;
    logic [`GP_W-1:0] level_rd;
    logic [`GP_W-1:0] stat;
    logic [`GP_W-1:0] flag;
    logic [`GP_W-1:0] flag_wr_val;
    logic [`GP_W-1:0] next_rd;
    logic [`GP_W-1:0] next_out;
    logic [`GP_W-1:0] next_oe;
    logic             flag_wr;
    logic             port_rd;
    logic             irq;

    // Alias write: base stores, others touch only bits written as one
    function automatic logic [`GP_W-1:0] apply(input logic [`GP_W-1:0] old,
                                              input logic [`GP_W-1:0] d,
                                              input gp_op_t           op);
        case (op)
            GP_CLR:  apply = old & ~d;   // [RQ20]
            GP_SET:  apply = old | d;    // [RQ20]
            GP_INV:  apply = old ^ d;    // [RQ20]
            default: apply = d;
        endcase
    endfunction

    // Reset value per stored register
    function automatic logic [`GP_W-1:0] rst_val(input int i);
        case (i)
            int'(`GP_R_DIR): rst_val = `GP_ONES;   // [RQ2]
            int'(`GP_R_ANS): rst_val = `GP_ONES;   // [RQ7]
            default:         rst_val = `GP_ZERO;   // [RQ19]
        endcase
    endfunction

    // Pin inputs into the clock domain
    gp_sync #(
        .W    (`GP_W)
    ) u_sync (
        .clk  (MCLK),
        .rstn (RSTN),
        .d    (PIN_IN),
        .q    (level)
    );

    // Strobes for the change detector
    assign port_rd     = REG_RD.en && REG_RD.sel == `GP_R_PORT && REG_RD.op == GP_BASE;
    assign flag_wr     = REG_WR.en && REG_WR.sel == `GP_R_CNF;
    assign flag_wr_val = apply(flag, REG_WR.data, REG_WR.op);

    // Change-notice detector
    gp_change #(
        .W           (`GP_W)
    ) u_change (
        .clk         (MCLK),
        .rstn        (RSTN),
        .level       (level),
        .mode        (r[`GP_R_CNCON][`GP_EDGE_BIT]),
        .rise_en     (r[`GP_R_CNEN]),
        .fall_en     (r[`GP_R_CNNE]),
        .port_rd     (port_rd),
        .flag_wr     (flag_wr),
        .flag_wr_val (flag_wr_val),
        .stat        (stat),
        .flag        (flag),
        .irq         (irq)
    );

    // Register writes; pin-level writes land in the latch
    always_comb begin
        for (int i = 0; i < `GP_NSTORE; i++) begin
            next_r[i] = r[i];
        end
        if (REG_WR.en) begin
            if (REG_WR.sel == `GP_R_PORT || REG_WR.sel == `GP_R_LAT) begin
                next_r[`GP_R_LAT] = apply(r[`GP_R_LAT], REG_WR.data, REG_WR.op); // [RQ3] [RQ4]
            end else if (REG_WR.sel == `GP_R_CNCON) begin
                next_r[`GP_R_CNCON] = apply(r[`GP_R_CNCON], REG_WR.data, REG_WR.op)
                                      & `GP_CNCON_MASK;
            end else if (REG_WR.sel < `GP_R_PORT) begin
                next_r[REG_WR.sel] = apply(r[REG_WR.sel], REG_WR.data, REG_WR.op);
            end
        end
    end

    // Analog inputs read back low
    assign level_rd = level & ~(r[`GP_R_ANS] & r[`GP_R_DIR]); // [RQ8]

    // Read data mux; alias reads give zero
    always_comb begin
        next_rd = `GP_ZERO;
        if (REG_RD.en && REG_RD.op == GP_BASE) begin
            case (REG_RD.sel)
                `GP_R_PORT:   next_rd = level_rd;           // [RQ4] [RQ22]
                `GP_R_CNSTAT: next_rd = stat;               // [RQ14]
                `GP_R_CNF:    next_rd = flag;               // [RQ15]
                default: begin
                    if (REG_RD.sel < `GP_R_PORT) begin
                        next_rd = r[REG_RD.sel];            // [RQ3]
                    end
                end
            endcase
        end else if (REG_RD.en) begin
            next_rd = `GP_ZERO;                             // [RQ21]
        end
    end

    // Pin drivers: inputs float, open-drain never drives high
    always_comb begin
        next_out = next_r[`GP_R_LAT] & ~next_r[`GP_R_ODC];                       // [RQ5]
        next_oe  = ~next_r[`GP_R_DIR] & ~(next_r[`GP_R_ODC] & next_r[`GP_R_LAT]); // [RQ1] [RQ5]
    end

    // Register file and registered outputs
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < `GP_NSTORE; i++) begin
                r[i] <= rst_val(i);
            end
            RD_DATA   <= `GP_ZERO;
            PIN_OUT   <= `GP_ZERO;
            PIN_OE    <= `GP_ZERO;
            ANALOG_EN <= `GP_ONES;
            PULL_UP   <= `GP_ZERO;
            PULL_DN   <= `GP_ZERO;
            SLEW_HI   <= `GP_ZERO;
            SLEW_LO   <= `GP_ZERO;
            CN_IRQ    <= 1'b0;
        end else begin
            for (int i = 0; i < `GP_NSTORE; i++) begin
                r[i] <= next_r[i];
            end
            RD_DATA   <= next_rd;
            PIN_OUT   <= next_out;
            PIN_OE    <= next_oe;
            ANALOG_EN <= next_r[`GP_R_ANS];
            PULL_UP   <= next_r[`GP_R_CNPU];   // [RQ16]
            PULL_DN   <= next_r[`GP_R_CNPD];   // [RQ16]
            SLEW_HI   <= next_r[`GP_R_SRH];    // [RQ18]
            SLEW_LO   <= next_r[`GP_R_SRL];    // [RQ18]
            CN_IRQ    <= irq;                  // [RQ10]
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    sequence s_lat_base_wr;
        REG_WR.en && REG_WR.op == GP_BASE
        && (REG_WR.sel == `GP_R_LAT || REG_WR.sel == `GP_R_PORT);
    endsequence

    sequence s_lat_set_wr;
        REG_WR.en && REG_WR.op == GP_SET && REG_WR.sel == `GP_R_LAT;
    endsequence

    a_reset_all_inputs: assert property ( // [RQ2]
        $rose(RSTN) |-> r[`GP_R_DIR] == `GP_ONES && PIN_OE == `GP_ZERO)
        else $error("pins not inputs after reset");

    a_reset_analog_slew: assert property ( // [RQ7]
        $rose(RSTN) |-> ANALOG_EN == `GP_ONES && SLEW_HI == `GP_ZERO && SLEW_LO == `GP_ZERO)
        else $error("analog or slew reset value wrong");

    a_latch_write: assert property ( // [RQ4]
        s_lat_base_wr |=> r[`GP_R_LAT] == $past(REG_WR.data))
        else $error("latch not written");

    a_set_alias: assert property ( // [RQ20]
        s_lat_set_wr |=> r[`GP_R_LAT] == ($past(r[`GP_R_LAT]) | $past(REG_WR.data)))
        else $error("set alias changed wrong bits");

    a_output_follows: assert property ( // [RQ1]
        s_lat_base_wr ##1 !REG_WR.en
        |-> PIN_OE == (~r[`GP_R_DIR] & ~(r[`GP_R_ODC] & r[`GP_R_LAT])))
        else $error("pin enable does not follow direction");

    a_open_drain_high: assert property ( // [RQ5]
        ##1 ((PIN_OE & $past(next_r[`GP_R_ODC] & next_r[`GP_R_LAT])) == `GP_ZERO)
        && ((PIN_OUT & $past(next_r[`GP_R_ODC])) == `GP_ZERO))
        else $error("open-drain pin driven high");

    a_analog_reads_zero: assert property ( // [RQ8]
        port_rd |=> (RD_DATA & $past(r[`GP_R_ANS] & r[`GP_R_DIR])) == `GP_ZERO)
        else $error("analog pin read as high");

    a_alias_read_zero: assert property ( // [RQ21]
        REG_RD.en && REG_RD.op != GP_BASE |=> RD_DATA == `GP_ZERO)
        else $error("alias read returned data");

    a_edge_irq: assert property ( // [RQ15]
        $past(r[`GP_R_CNCON][`GP_EDGE_BIT]) && r[`GP_R_CNCON][`GP_EDGE_BIT]
        && flag != `GP_ZERO && !flag_wr |=> CN_IRQ [*2])
        else $error("edge flag without request");

    // Further register-side steps watched below
    sequence s_lat_clr_wr;
        REG_WR.en && REG_WR.op == GP_CLR && REG_WR.sel == `GP_R_LAT;
    endsequence

    sequence s_lat_inv_wr;
        REG_WR.en && REG_WR.op == GP_INV && REG_WR.sel == `GP_R_LAT;
    endsequence

    sequence s_lat_base_rd;
        REG_RD.en && REG_RD.op == GP_BASE && REG_RD.sel == `GP_R_LAT;
    endsequence

    sequence s_stat_base_rd;
        REG_RD.en && REG_RD.op == GP_BASE && REG_RD.sel == `GP_R_CNSTAT;
    endsequence

    sequence s_flag_base_rd;
        REG_RD.en && REG_RD.op == GP_BASE && REG_RD.sel == `GP_R_CNF;
    endsequence

    // Alias writes leave bits written as zero alone
    a_clr_alias: assert property ( // [RQ20]
        s_lat_clr_wr |=> r[`GP_R_LAT] == ($past(r[`GP_R_LAT]) & ~$past(REG_WR.data)))
        else $error("clear alias changed wrong bits");

    a_inv_alias: assert property ( // [RQ20]
        s_lat_inv_wr |=> r[`GP_R_LAT] == ($past(r[`GP_R_LAT]) ^ $past(REG_WR.data)))
        else $error("invert alias changed wrong bits");

    // Base reads return the stored or detected values
    a_latch_read: assert property ( // [RQ3]
        s_lat_base_rd |=> RD_DATA == $past(r[`GP_R_LAT]))
        else $error("latch read returned wrong data");

    a_status_read: assert property ( // [RQ14]
        s_stat_base_rd |=> RD_DATA == $past(stat))
        else $error("status read returned wrong data");

    a_flag_read: assert property ( // [RQ15]
        s_flag_base_rd |=> RD_DATA == $past(flag))
        else $error("edge flag read returned wrong data");

    // An input pin never has its driver enabled
    a_input_not_driven: assert property ( // [RQ1]
        (PIN_OE & r[`GP_R_DIR]) == `GP_ZERO)
        else $error("input pin has its driver enabled");

    // Only the edge mode bit is kept in the control register
    a_control_bits: assert property ( // [RQ12]
        (r[`GP_R_CNCON] & ~`GP_CNCON_MASK) == `GP_ZERO)
        else $error("unused control bit stored");

    // Base writes reach the pin control outputs one edge later
    a_pull_up_write: assert property ( // [RQ16]
        REG_WR.en && REG_WR.op == GP_BASE && REG_WR.sel == `GP_R_CNPU
        |=> PULL_UP == $past(REG_WR.data))
        else $error("pull-up enables not applied");

    a_pull_dn_write: assert property ( // [RQ16]
        REG_WR.en && REG_WR.op == GP_BASE && REG_WR.sel == `GP_R_CNPD
        |=> PULL_DN == $past(REG_WR.data))
        else $error("pull-down enables not applied");

    a_slew_write: assert property ( // [RQ18]
        REG_WR.en && REG_WR.op == GP_BASE && REG_WR.sel == `GP_R_SRH
        |=> SLEW_HI == $past(REG_WR.data))
        else $error("slew code not applied");
endmodule

/* File: dv/gp_pin_model.sv */
// Model of the devices wired to the port pins.
// Assumes the port's pin controls and the bus clock; ext_en/ext_val come from the bench.
`timescale 1ns/100ps

module gp_pin_model (
    input  wire logic        clk,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] pull_up,
    input  wire logic [15:0] pull_dn,
    input  wire logic [15:0] ext_en,
    input  wire logic [15:0] ext_val,
    output logic      [15:0] pin_in
);
    logic [15:0] drift = 16'h0000;

    // Undriven pins with no weak pull toggle each cycle, so the port's agreement filter keeps their last agreed level
    always_ff @(posedge clk) begin
        drift <= ~drift;
    end

    // Port driver wins, then the external device, then weak up, then weak down
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pull_up | (~pull_dn & drift)));
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the I/O port: register tasks and directed tests.
// Assumes the port package, its constant header and the pin model are compiled first.
`timescale 1ns/100ps
`include "gp_port_map.svh"

module testbench;
    import gp_port_pkg::*;

    logic             mclk;
    logic             rstn;
    gp_wr_t           reg_wr;
    gp_rd_t           reg_rd;
    logic [`GP_W-1:0] rd_data, pin_in, pin_out, pin_oe, analog_en;
    logic [`GP_W-1:0] pull_up, pull_dn, slew_hi, slew_lo, ext_en, ext_val;
    logic             cn_irq;
    int               fail_count = 0;
    int               comparisons = 0;

    gp_port dut (.MCLK(mclk), .RSTN(rstn), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .RD_DATA(rd_data), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .ANALOG_EN(analog_en), .PULL_UP(pull_up), .PULL_DN(pull_dn),
        .SLEW_HI(slew_hi), .SLEW_LO(slew_lo), .CN_IRQ(cn_irq));

    gp_pin_model pins_far (.clk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up(pull_up), .pull_dn(pull_dn), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    // Clock at 40 MHz
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One write, taken at the next edge, then the strobe drops
    task automatic wr(input logic [3:0] sel, input gp_op_t op, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= '{1'b1, sel, op, d};
        @(posedge mclk);
        reg_wr.en <= 1'b0;
        #1;
    endtask

    // One read; data stands for the single cycle after the taking edge
    task automatic rd(input logic [3:0] sel, input gp_op_t op, output logic [15:0] q);
        @(posedge mclk);
        reg_rd <= '{1'b1, sel, op};
        @(posedge mclk);
        reg_rd.en <= 1'b0;
        #1 q = rd_data;
    endtask

    task automatic rdchk(input logic [3:0] sel, input gp_op_t op, input logic [15:0] exp);
        logic [15:0] q;
        rd(sel, op, q);
        chk(q, exp);
    endtask

    // Far side changes pin levels, then the synchroniser is given time
    task automatic drive_pins(input logic [15:0] v);
        @(posedge mclk);
        ext_val <= v;
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic done(input string name);
        $display("test %s finished, %0d mismatches so far", name, fail_count);
    endtask

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        close_out();
    end

    initial begin
        rstn = 1'b0;
        reg_wr = '0;
        reg_rd = '0;
        ext_en = 16'hFFFF;
        ext_val = 16'h0000;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        // Reset state
        rdchk(`GP_R_DIR, GP_BASE, 16'hFFFF);
        rdchk(`GP_R_ANS, GP_BASE, 16'hFFFF);
        chk(analog_en, 16'hFFFF);
        chk(pin_oe, 16'h0000);
        chk(slew_hi | slew_lo, 16'h0000);
        done("reset");
        // Latch writes and the clear, set and invert aliases
        wr(`GP_R_LAT, GP_BASE, 16'hA5A5);
        rdchk(`GP_R_LAT, GP_BASE, 16'hA5A5);
        wr(`GP_R_LAT, GP_SET, 16'h000F);
        rdchk(`GP_R_LAT, GP_BASE, 16'hA5AF);
        wr(`GP_R_LAT, GP_CLR, 16'h00A0);
        rdchk(`GP_R_LAT, GP_BASE, 16'hA50F);
        wr(`GP_R_LAT, GP_INV, 16'hFFFF);
        rdchk(`GP_R_LAT, GP_BASE, 16'h5AF0);
        rdchk(`GP_R_LAT, GP_SET, 16'h0000);
        done("latch");
        // Outputs from the latch, then open drain on the low byte
        wr(`GP_R_ANS, GP_BASE, 16'h0000);
        wr(`GP_R_DIR, GP_CLR, 16'h00FF);
        chk(pin_oe, 16'h00FF);
        chk(pin_out & pin_oe, 16'h00F0);
        wr(`GP_R_ODC, GP_BASE, 16'h00FF);
        chk(pin_oe, 16'h000F);
        chk(pin_out & 16'h00FF, 16'h0000);
        done("direction");
        // Pin level reads, analog masking and writes landing in the latch
        wr(`GP_R_DIR, GP_BASE, 16'hFFFF);
        wr(`GP_R_ANS, GP_BASE, 16'h00FF);
        drive_pins(16'h1234);
        rdchk(`GP_R_PORT, GP_BASE, 16'h1200);
        wr(`GP_R_PORT, GP_BASE, 16'h0F0F);
        rdchk(`GP_R_LAT, GP_BASE, 16'h0F0F);
        rdchk(`GP_R_PORT, GP_BASE, 16'h1200);
        done("pin level");
        // Weak pulls on input pins only, and every slew code
        wr(`GP_R_CNPU, GP_BASE, 16'h8001);
        wr(`GP_R_CNPD, GP_BASE, 16'h0180);
        chk(pull_up, 16'h8001);
        chk(pull_dn, 16'h0180);
        // Released pins settle to their weak pulls
        @(posedge mclk);
        ext_en <= 16'h7E7E;
        drive_pins(16'h1234);
        rdchk(`GP_R_PORT, GP_BASE, 16'h9200);
        @(posedge mclk);
        ext_en <= 16'hFFFF;
        drive_pins(16'h1234);
        for (int c = 0; c < 4; c++) begin
            wr(`GP_R_SRH, GP_BASE, {16{c[1]}});
            wr(`GP_R_SRL, GP_BASE, {16{c[0]}});
            chk(slew_hi, {16{c[1]}});
            chk(slew_lo, {16{c[0]}});
        end
        done("pulls and slew");
        // Mismatch mode: status since the last pin level read
        wr(`GP_R_ANS, GP_BASE, 16'h0000);
        wr(`GP_R_CNEN, GP_BASE, 16'h0001);
        rdchk(`GP_R_PORT, GP_BASE, 16'h1234);
        drive_pins(16'h1225);
        rdchk(`GP_R_CNSTAT, GP_BASE, 16'h0011);
        chk({15'h0000, cn_irq}, 16'h0001);
        wr(`GP_R_CNEN, GP_BASE, 16'h0002);
        rdchk(`GP_R_CNSTAT, GP_BASE, 16'h0011);
        chk({15'h0000, cn_irq}, 16'h0000);
        rdchk(`GP_R_PORT, GP_BASE, 16'h1225);
        rdchk(`GP_R_CNSTAT, GP_BASE, 16'h0000);
        done("mismatch");
        // Edge mode: pin 1 armed for rising, pin 2 for falling
        wr(`GP_R_CNCON, GP_BASE, 16'h0800);
        wr(`GP_R_CNNE, GP_BASE, 16'h0004);
        wr(`GP_R_CNF, GP_CLR, 16'hFFFF);
        rdchk(`GP_R_CNF, GP_BASE, 16'h0000);
        drive_pins(16'h1223);
        rdchk(`GP_R_CNF, GP_BASE, 16'h0006);
        chk({15'h0000, cn_irq}, 16'h0001);
        drive_pins(16'h1225);
        wr(`GP_R_CNF, GP_CLR, 16'h0006);
        rdchk(`GP_R_CNF, GP_BASE, 16'h0000);
        chk({15'h0000, cn_irq}, 16'h0000);
        done("edge");
        // A clear in the very cycle that an armed edge arrives loses to it
        @(posedge mclk);
        ext_val <= 16'h1223;
        repeat (3) @(posedge mclk);
        wr(`GP_R_CNF, GP_CLR, 16'hFFFF);
        rdchk(`GP_R_CNF, GP_BASE, 16'h0006);
        done("edge against clear");
        // Mid-run reset: every pin input and analog again, slew fastest
        wr(`GP_R_DIR, GP_CLR, 16'h00FF);
        chk(pin_oe, 16'h00F0);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        chk(pin_oe, 16'h0000);
        chk(analog_en, 16'hFFFF);
        chk(slew_hi | slew_lo, 16'h0000);
        rdchk(`GP_R_DIR, GP_BASE, 16'hFFFF);
        done("mid-run reset");
        close_out();
    end
endmodule
